// [pkg/wdt_pkg.sv]
// Package with register map, field positions and timing constants of the watchdog.
package wdt_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK = 4'h8;
  localparam int CTL_ON = 15;
  localparam int CTL_PS_LO = 2;
  localparam int CTL_PS_HI = 6;
  localparam int CTL_WIN = 1;
  localparam int CTL_CLR = 0;
  localparam int PS_W = 5;
  localparam int CNT_W = 32;
  localparam int EVT_W = 3;
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_WINVIOL = 1;
  localparam int EVT_WAKE = 2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [EVT_W-1:0] EVT_NONE = 3'h0;
  localparam int PS_MAX = 20;
endpackage

// [verif/wdt_tb_top.sv]
// Self-checking bench for the watchdog core: register bus, timeout, window, sleep and interrupt.
`timescale 1ns/10ps
module windowed_watchdog_timer_tb_top;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic lowPowerRcOsc = 1'h0;
  logic cfgEnable = 1'h0;
  logic sleepMode = 1'h0;
  logic wrStrobe = 1'h0;
  logic rdStrobe = 1'h0;
  logic [4:0] cfgPostscaleSelect = 5'h00;
  logic [3:0] addr = 4'h0;
  logic [31:0] wrData = 32'h0000_0000;
  logic [31:0] rdData;
  logic [31:0] got;
  logic deviceReset;
  logic wakeRequest;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  int nRst = 0;
  int nWake = 0;
  int seed = 32'he66faded;
  int ps;
  int term;
  int sh;

  wwt_core i_dut (.mclk(mclk), .rst(rst), .lowPowerRcOsc(lowPowerRcOsc), .cfgEnable(cfgEnable),
    .cfgPostscaleSelect(cfgPostscaleSelect), .sleepMode(sleepMode), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .deviceReset(deviceReset), .wakeRequest(wakeRequest), .irq(irq));

  initial forever #4 mclk = ~mclk;

  always @(posedge mclk) begin
    nRst += (deviceReset === 1'h1);
    nWake += (wakeRequest === 1'h1);
  end

  task automatic chk(string name, logic [31:0] expv, logic [31:0] seen);
    checks++;
    if (seen !== expv) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'h1;
    @(posedge mclk);
    wrStrobe <= 1'h0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'h1;
    @(posedge mclk);
    rdStrobe <= 1'h0;
    #1 got = rdData;
  endtask

  // Each oscillator period is eight system cycles, then the counter is left to settle.
  task automatic tick(int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      lowPowerRcOsc <= 1'h1;
      repeat (4) @(posedge mclk);
      lowPowerRcOsc <= 1'h0;
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  initial begin
    ps = 2 + {$random(seed)} % 3;
    cfgPostscaleSelect = ps[4:0];
    term = 1 << ps;
    sh = ps << 2;
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    rd(wdt_pkg::OFF_CONTROL);
    chk("control after reset", sh, got);
    wr(wdt_pkg::OFF_CONTROL, 32'hffff_fffe);
    rd(wdt_pkg::OFF_CONTROL);
    chk("control all ones", 32'h0000_8002 | sh, got);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8000);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8001);
    wr(wdt_pkg::OFF_MASK, 32'h0000_0007);
    tick(term - 1);
    chk("reset before timeout", 0, nRst);
    tick(1);
    chk("reset at timeout", 1, nRst);
    chk("irq raised", 1, 32'(irq));
    rd(wdt_pkg::OFF_STATUS);
    chk("status timeout", 1, got);
    wr(wdt_pkg::OFF_STATUS, 32'h0000_0001);
    #1;
    chk("irq cleared", 0, 32'(irq));
    repeat (3) begin
      tick(term - 1);
      wr(wdt_pkg::OFF_CONTROL, 32'h0000_8001);
    end
    chk("clears keep alive", 1, nRst);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8003);
    tick(1);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8003);
    repeat (3) @(posedge mclk);
    chk("early clear", 2, nRst);
    rd(wdt_pkg::OFF_STATUS);
    chk("status violation", 2, got);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8000);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8002);
    tick(term - 1);
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8003);
    repeat (3) @(posedge mclk);
    chk("late clear", 2, nRst);
    wr(wdt_pkg::OFF_STATUS, 32'h0000_0007);
    sleepMode <= 1'h1;
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_8000);
    tick(term);
    chk("wake count", 1, nWake);
    chk("no reset in sleep", 2, nRst);
    rd(wdt_pkg::OFF_STATUS);
    chk("status wake", 4, got);
    sleepMode <= 1'h0;
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_0000);
    rd(wdt_pkg::OFF_CONTROL);
    chk("stopped", sh, got);
    tick(term + 1);
    chk("no reset stopped", 2, nRst);
    cfgEnable <= 1'h1;
    wr(wdt_pkg::OFF_CONTROL, 32'h0000_0001);
    rd(wdt_pkg::OFF_CONTROL);
    chk("config enabled", 32'h0000_8000 | sh, got);
    tick(term);
    chk("config timeout", 3, nRst);
    wr(4'hc, $random(seed));
    rd(4'hc);
    chk("unmapped", 0, got);
    rd(wdt_pkg::OFF_CONTROL);
    chk("control kept", 32'h0000_8000 | sh, got);
    give_verdict();
  end
endmodule

// [verilog/wdt_core.sv]
// Windowed watchdog timer with control, interrupt status and mask registers.
`timescale 1ns/10ps
// Behaviour
// - counter advances on low-power oscillator ticks
// - missed clear causes device reset
// - postscaler selects timeout length
// - expiry during sleep mode wakes
// - enable bit starts/stops software-enabled watchdog
// - enable reads one whenever running
// - shadow postscale bits loaded in first cycle after reset
// - window enable selects windowed mode
// - writing one to clear restarts count
// - unimplemented control bits read zero
module wwt_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lowPowerRcOsc,
  input wire logic cfgEnable,
  input wire logic [4:0] cfgPostscaleSelect,
  input wire logic sleepMode,
  input wire logic [3:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  output logic deviceReset,
  output logic wakeRequest,
  output logic irq
);
  logic oscSync;
  logic oscPrevReg;
  logic oscPrevNext;
  logic tick;
  logic swOnReg;
  logic swOnNext;
  logic winEnReg;
  logic winEnNext;
  logic [4:0] psShadowReg;
  logic [4:0] psShadowNext;
  logic psLoadedReg;
  logic psLoadedNext;
  logic [31:0] countReg;
  logic [31:0] countNext;
  logic resetReg;
  logic resetNext;
  logic wakeReg;
  logic wakeNext;
  logic [2:0] statusReg;
  logic [2:0] statusNext;
  logic [2:0] maskReg;
  logic [2:0] maskNext;
  logic [31:0] rdDataNext;
  logic running;
  logic [31:0] terminal;
  logic [31:0] windowOpen;
  logic clrWrite;
  logic ctlWrite;
  logic expire;
  logic earlyClear;
  logic [2:0] events;

  // The oscillator pin is a foreign clock; it is sampled, never used as a clock edge.
  wwt_sync2 oscSyncInst (
    .mclk(mclk),
    .rst(rst),
    .din(lowPowerRcOsc),
    .dout(oscSync)
  );

  always_comb begin
    oscPrevNext = oscSync;
    tick = oscSync & ~oscPrevReg;
  end

  always_comb begin
    ctlWrite = wrStrobe && (addr == wdt_pkg::OFF_CONTROL);
    clrWrite = ctlWrite && wrData[wdt_pkg::CTL_CLR];
    running = cfgEnable | swOnReg;
    // Timeout is 2^(shadow) oscillator ticks, capped at 2^PS_MAX (2^20) ticks.
    if (psShadowReg > 5'(wdt_pkg::PS_MAX)) begin
      terminal = wdt_pkg::CNT_ONE << wdt_pkg::PS_MAX;
    end else begin
      terminal = wdt_pkg::CNT_ONE << psShadowReg;
    end
    // The clear window opens at the last quarter of the period.
    windowOpen = terminal - (terminal >> 2);
    expire = running && tick && (countReg + wdt_pkg::CNT_ONE >= terminal);
    earlyClear = running && winEnReg && clrWrite && (countReg < windowOpen);
  end

  always_comb begin
    swOnNext = swOnReg;
    winEnNext = winEnReg;
    if (ctlWrite) begin
      // Writing zero only affects a software enable; configuration enable holds.
      swOnNext = wrData[wdt_pkg::CTL_ON];
      winEnNext = wrData[wdt_pkg::CTL_WIN];
    end
    psLoadedNext = 1'b1;
    psShadowNext = psShadowReg;
    if (!psLoadedReg) begin
      psShadowNext = cfgPostscaleSelect;
    end
  end

  always_comb begin
    countNext = countReg;
    if (!running || clrWrite || !psLoadedReg) begin
      countNext = wdt_pkg::CNT_ZERO;
    end else if (tick) begin
      countNext = expire ? wdt_pkg::CNT_ZERO : countReg + wdt_pkg::CNT_ONE;
    end
    resetNext = 1'b0;
    wakeNext = 1'b0;
    if (expire && sleepMode) begin
      wakeNext = 1'b1;
    end else if (expire) begin
      resetNext = 1'b1;
    end
    if (earlyClear) begin
      resetNext = 1'b1;
    end
  end

  always_comb begin
    events = wdt_pkg::EVT_NONE;
    events[wdt_pkg::EVT_TIMEOUT] = expire && !sleepMode;
    events[wdt_pkg::EVT_WINVIOL] = earlyClear;
    events[wdt_pkg::EVT_WAKE] = expire && sleepMode;
    statusNext = statusReg;
    maskNext = maskReg;
    if (wrStrobe && (addr == wdt_pkg::OFF_STATUS)) begin
      statusNext = statusReg & ~wrData[wdt_pkg::EVT_W-1:0];
    end else if (wrStrobe && (addr == wdt_pkg::OFF_MASK)) begin
      maskNext = wrData[wdt_pkg::EVT_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    statusNext = statusNext | events;
  end

  always_comb begin
    rdDataNext = wdt_pkg::ZERO_WORD;
    if (rdStrobe && (addr == wdt_pkg::OFF_CONTROL)) begin
      rdDataNext[wdt_pkg::CTL_ON] = running;
      rdDataNext[wdt_pkg::CTL_PS_HI:wdt_pkg::CTL_PS_LO] = psShadowReg;
      rdDataNext[wdt_pkg::CTL_WIN] = winEnReg;
    end else if (rdStrobe && (addr == wdt_pkg::OFF_STATUS)) begin
      rdDataNext[wdt_pkg::EVT_W-1:0] = statusReg;
    end else if (rdStrobe && (addr == wdt_pkg::OFF_MASK)) begin
      rdDataNext[wdt_pkg::EVT_W-1:0] = maskReg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscPrevReg <= 1'b0;
      swOnReg <= 1'b0;
      winEnReg <= 1'b0;
      psShadowReg <= 5'h0_0;
      psLoadedReg <= 1'b0;
      countReg <= wdt_pkg::CNT_ZERO;
      resetReg <= 1'b0;
      wakeReg <= 1'b0;
      statusReg <= wdt_pkg::EVT_NONE;
      maskReg <= wdt_pkg::EVT_NONE;
      rdData <= wdt_pkg::ZERO_WORD;
    end else begin
      oscPrevReg <= oscPrevNext;
      swOnReg <= swOnNext;
      winEnReg <= winEnNext;
      psShadowReg <= psShadowNext;
      psLoadedReg <= psLoadedNext;
      countReg <= countNext;
      resetReg <= resetNext;
      wakeReg <= wakeNext;
      statusReg <= statusNext;
      maskReg <= maskNext;
      rdData <= rdDataNext;
    end
  end

  assign deviceReset = resetReg;
  assign wakeRequest = wakeReg;
  assign irq = |(statusReg & maskReg);

  property p_timeout_reset;
    @(posedge mclk) disable iff (rst) (expire && !sleepMode) |=> deviceReset;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");

  property p_sleep_wake;
    @(posedge mclk) disable iff (rst) (expire && sleepMode) |=> (wakeRequest && !deviceReset);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on sleep expiry");

  property p_clear_restart;
    @(posedge mclk) disable iff (rst) (clrWrite && !earlyClear) |=> (countReg == wdt_pkg::CNT_ZERO);
  endproperty
  a_clear_restart: assert property (p_clear_restart) else $error("clear did not restart");

  property p_on_read;
    @(posedge mclk) disable iff (rst)
      (rdStrobe && addr == wdt_pkg::OFF_CONTROL && (cfgEnable || swOnReg))
      |=> rdData[wdt_pkg::CTL_ON];
  endproperty
  a_on_read: assert property (p_on_read) else $error("enable bit read wrong");

  property p_zero_bits;
    @(posedge mclk) disable iff (rst)
      (rdStrobe && addr == wdt_pkg::OFF_CONTROL)
      |=> (rdData[wdt_pkg::CNT_W-1:wdt_pkg::CTL_ON+1] == '0
           && rdData[wdt_pkg::CTL_ON-1:wdt_pkg::CTL_PS_HI+1] == '0);
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits not zero");

  property p_sw_on;
    @(posedge mclk) disable iff (rst) (ctlWrite && wrData[wdt_pkg::CTL_ON]) |=> running;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("software enable failed");

  property p_window;
    @(posedge mclk) disable iff (rst) (ctlWrite && wrData[wdt_pkg::CTL_WIN]) |=> winEnReg;
  endproperty
  a_window: assert property (p_window) else $error("window enable not taken");

  property p_early;
    @(posedge mclk) disable iff (rst) earlyClear |=> deviceReset;
  endproperty
  a_early: assert property (p_early) else $error("early clear not punished");

  property p_idle_count;
    @(posedge mclk) disable iff (rst) (!running) |=> (countReg == wdt_pkg::CNT_ZERO);
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("count moved while stopped");

  // A control write without the clear bit must leave the count advancing.
  property p_count_step;
    @(posedge mclk) disable iff (rst)
      (running && psLoadedReg && tick && !expire && !clrWrite)
      |=> (countReg == $past(countReg) + wdt_pkg::CNT_ONE);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  // Software may only stop what software started.
  property p_sw_off;
    @(posedge mclk) disable iff (rst)
      (ctlWrite && !wrData[wdt_pkg::CTL_ON] && !cfgEnable)
      |=> !running;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("software disable failed");

  property p_window_off;
    @(posedge mclk) disable iff (rst)
      (ctlWrite && !wrData[wdt_pkg::CTL_WIN])
      |=> !winEnReg;
  endproperty
  a_window_off: assert property (p_window_off) else $error("window enable not cleared");

  // Without the window any clear is legal and must not reset the device.
  property p_plain_clear;
    @(posedge mclk) disable iff (rst)
      (clrWrite && !winEnReg && !expire)
      |=> !deviceReset;
  endproperty
  a_plain_clear: assert property (p_plain_clear) else $error("plain clear caused reset");

  // The shadow copy is taken once after reset and then held.
  property p_shadow_hold;
    @(posedge mclk) disable iff (rst)
      psLoadedReg
      |=> $stable(psShadowReg);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow copy changed");

  // Ticks are far apart, so a wake request is a single cycle.
  property p_wake_pulse;
    @(posedge mclk) disable iff (rst)
      wakeRequest
      |=> !wakeRequest;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake request too long");

  // Read data stand only in the cycle after a read strobe.
  property p_rd_idle;
    @(posedge mclk) disable iff (rst)
      !rdStrobe
      |=> (rdData == wdt_pkg::ZERO_WORD);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

  property p_status_upper;
    @(posedge mclk) disable iff (rst)
      (rdStrobe && addr == wdt_pkg::OFF_STATUS)
      |=> (rdData[wdt_pkg::CNT_W-1:wdt_pkg::EVT_W] == '0);
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits not zero");

  // A set event bit stays set until software writes a one over it.
  property p_status_sticky;
    @(posedge mclk) disable iff (rst)
      (statusReg[wdt_pkg::EVT_TIMEOUT] && !(wrStrobe && addr == wdt_pkg::OFF_STATUS))
      |=> statusReg[wdt_pkg::EVT_TIMEOUT];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("timeout status lost");
endmodule

// [verilog/wdt_sync2.sv]
// Two-flop synchroniser for a level from another clock domain.
`timescale 1ns/10ps
module wwt_sync2 (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic stage1Reg;
  logic stage1Next;
  logic stage2Next;

  always_comb begin
    stage1Next = din;
    stage2Next = stage1Reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1Reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1Reg <= stage1Next;
      dout <= stage2Next;
    end
  end
endmodule
